// File: core/rf_pkg.sv
// constants and carrier types of the banked register file
// ====================================================================
// Summary of operation
// - wide state: sixteen registers plus status words
// - registers 0 to 12 are plain storage
// - branch_and_link copies pc into current link
// - exception entry loads new mode link register
// - wide state: pc bits 1:0 read zero
// - compact state: pc bit 0 reads zero
// - privileged modes other than system see their saved status word
// - fast interrupt banks registers 8 to 14
// - other privileged modes except system bank registers 13, 14
// - one current, five saved status words
// - status holds flags, interrupt masks, mode
// - compact state reaches low, stack, link, pc
// - low registers shared by both states
// - compact sp, lr, pc are 13, 14, 15
// - both states share all status words
// - move_instruction reaches high registers in compact
// - compare_instruction and add read high registers
// - mode field codes select the bank
// - status compact flag selects the register view
package rf_pkg;
    // ================================================================
    // geometry
    localparam int PHYS_GPR = 30;
    localparam int NSAVED = 5;
    localparam logic [3:0] LOW_LAST = 4'h7;
    localparam logic [3:0] FIQ_FIRST = 4'h8;
    localparam logic [3:0] SP_IDX = 4'hD;
    localparam logic [3:0] LINK_IDX = 4'hE;
    localparam logic [3:0] PC_IDX = 4'hF;
    localparam logic [4:0] FIQ_BASE = 5'h0F;
    localparam logic [4:0] IRQ_BASE = 5'h16;
    localparam logic [4:0] SVC_BASE = 5'h18;
    localparam logic [4:0] ABT_BASE = 5'h1A;
    localparam logic [4:0] UND_BASE = 5'h1C;
    // ================================================================
    // mode codes
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [4:0] MODE_SYS = 5'h1F;
    // ================================================================
    // reset values and bus offsets
    localparam logic [31:0] STATUS_RESET = 32'h000000D3;
    localparam logic [31:0] PC_RESET = 32'h00000000;
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_SAVED = 8'h04;
    localparam logic [7:0] OFS_PC = 8'h08;
    localparam logic [7:0] OFS_VIEW = 8'h0C;
    // ================================================================
    // carriers
    typedef struct packed {
        logic [3:0] flags;
        logic [19:0] reserved;
        logic irq_off;
        logic fiq_off;
        logic compact;
        logic [4:0] mode;
    } psr_t;
    typedef struct packed {
        logic [3:0] idx;
        logic hi;
    } rd_req_t;
    typedef struct packed {
        logic en;
        logic [3:0] idx;
        logic hi;
        logic [31:0] data;
    } wr_req_t;
    typedef enum logic [2:0] {BANK_USR, BANK_FIQ, BANK_IRQ, BANK_SVC, BANK_ABT, BANK_UND} bank_t;
endpackage

// File: core/banked_register_file.sv
// banked general and status register file with wishbone view
`timescale 1ns/1ns
module banked_register_file (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire rf_pkg::rd_req_t rd_a_i,
    input wire rf_pkg::rd_req_t rd_b_i,
    output logic [31:0] rd_a_o,
    output logic [31:0] rd_b_o,
    input wire rf_pkg::wr_req_t wr_i,
    input wire logic pc_we_i,
    input wire logic [31:0] pc_i,
    output logic [31:0] pc_o,
    input wire logic branch_and_link_i,
    input wire logic exc_enter_i,
    input wire logic [4:0] exc_mode_i,
    input wire logic [31:0] exc_ret_i,
    input wire logic status_we_i,
    input wire rf_pkg::psr_t status_i,
    input wire logic saved_we_i,
    input wire rf_pkg::psr_t saved_i,
    output rf_pkg::psr_t current_status_word_o,
    output rf_pkg::psr_t saved_status_word_o,
    output logic compact_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    // ================================================================
    // decoding helpers
    // mode code to bank
    function automatic rf_pkg::bank_t bank_of(input logic [4:0] m);
        case (m)
            rf_pkg::MODE_FIQ: bank_of = rf_pkg::BANK_FIQ;
            rf_pkg::MODE_IRQ: bank_of = rf_pkg::BANK_IRQ;
            rf_pkg::MODE_SVC: bank_of = rf_pkg::BANK_SVC;
            rf_pkg::MODE_ABT: bank_of = rf_pkg::BANK_ABT;
            rf_pkg::MODE_UND: bank_of = rf_pkg::BANK_UND;
            default: bank_of = rf_pkg::BANK_USR;
        endcase
    endfunction

    function automatic logic [4:0] phys_of(input rf_pkg::bank_t b, input logic [3:0] r);
        logic [4:0] p;
        p = 5'(r);
        if (b == rf_pkg::BANK_FIQ && r >= rf_pkg::FIQ_FIRST) begin
            p = rf_pkg::FIQ_BASE + 5'(r - rf_pkg::FIQ_FIRST);
        end else if (r >= rf_pkg::SP_IDX) begin
            case (b)
                rf_pkg::BANK_IRQ: p = rf_pkg::IRQ_BASE + 5'(r - rf_pkg::SP_IDX);
                rf_pkg::BANK_SVC: p = rf_pkg::SVC_BASE + 5'(r - rf_pkg::SP_IDX);
                rf_pkg::BANK_ABT: p = rf_pkg::ABT_BASE + 5'(r - rf_pkg::SP_IDX);
                rf_pkg::BANK_UND: p = rf_pkg::UND_BASE + 5'(r - rf_pkg::SP_IDX);
                default: p = 5'(r);
            endcase
        end
        return p;
    endfunction

    function automatic logic [2:0] slot_of(input rf_pkg::bank_t b);
        case (b)
            rf_pkg::BANK_IRQ: slot_of = 3'h1;
            rf_pkg::BANK_SVC: slot_of = 3'h2;
            rf_pkg::BANK_ABT: slot_of = 3'h3;
            rf_pkg::BANK_UND: slot_of = 3'h4;
            default: slot_of = 3'h0;
        endcase
    endfunction

    function automatic logic reach_ok(input logic t, input logic hi, input logic [3:0] r);
        return !t || hi || r <= rf_pkg::LOW_LAST || r >= rf_pkg::SP_IDX;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++) begin
            if (sel[k]) begin
                res[8*k +: 8] = nw[8*k +: 8];
            end
        end
        return res;
    endfunction

    // ================================================================
    // storage and decode
    logic [31:0] gpr [rf_pkg::PHYS_GPR];
    logic [31:0] pc;
    rf_pkg::psr_t status_word;
    rf_pkg::psr_t saved_words [rf_pkg::NSAVED];
    rf_pkg::bank_t bank;
    rf_pkg::bank_t exc_bank;
    logic compact;
    logic has_saved;
    logic [2:0] slot;
    logic [2:0] exc_slot;
    logic [31:0] pc_view;
    logic wr_ok;
    logic [4:0] wr_phys;
    logic [4:0] link_phys;
    logic [4:0] exc_link;
    logic wb_hit;
    logic wb_wr;
    logic [7:0] wb_ofs;
    logic gpr_write_any;

    assign bank = bank_of(status_word.mode);
    assign exc_bank = bank_of(exc_mode_i);
    assign compact = status_word.compact;
    assign has_saved = bank != rf_pkg::BANK_USR;
    assign slot = slot_of(bank);
    assign exc_slot = slot_of(exc_bank);
    assign pc_view = compact ? {pc[31:1], 1'b0} : {pc[31:2], 2'b00};
    assign wr_ok = wr_i.en && reach_ok(compact, wr_i.hi, wr_i.idx);
    assign wr_phys = phys_of(bank, wr_i.idx);
    assign link_phys = phys_of(bank, rf_pkg::LINK_IDX);
    assign exc_link = phys_of(exc_bank, rf_pkg::LINK_IDX);
    assign gpr_write_any = (wr_ok && wr_i.idx != rf_pkg::PC_IDX) || branch_and_link_i || exc_enter_i;

    // ================================================================
    // general registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rf_pkg::PHYS_GPR; i++) begin
                gpr[i] <= '0;
            end
        end else begin
            if (wr_ok && wr_i.idx != rf_pkg::PC_IDX) begin
                gpr[wr_phys] <= wr_i.data;
            end
            if (branch_and_link_i) begin
                gpr[link_phys] <= pc_view;
            end
            if (exc_enter_i) begin
                gpr[exc_link] <= exc_ret_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= rf_pkg::PC_RESET;
        end else if (wr_ok && wr_i.idx == rf_pkg::PC_IDX) begin
            pc <= wr_i.data;
        end else if (pc_we_i) begin
            pc <= pc_i;
        end
    end

    // ================================================================
    // read ports
    function automatic logic [31:0] read_val(input rf_pkg::rd_req_t q);
        if (!reach_ok(compact, q.hi, q.idx)) begin
            return '0;
        end else if (q.idx == rf_pkg::PC_IDX) begin
            return pc_view;
        end
        return gpr[phys_of(bank, q.idx)];
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_a_o <= '0;
            rd_b_o <= '0;
        end else begin
            rd_a_o <= read_val(rd_a_i);
            rd_b_o <= read_val(rd_b_i);
        end
    end

    // ================================================================
    // status words
    assign wb_hit = wb_cyc_i && wb_stb_i;
    assign wb_wr = wb_hit && wb_we_i && wb_ack_o;
    assign wb_ofs = {wb_adr_i[7:2], 2'b00};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_word <= rf_pkg::psr_t'(rf_pkg::STATUS_RESET);
        end else if (exc_enter_i) begin
            status_word.mode <= exc_mode_i;
            status_word.compact <= 1'b0;
            status_word.irq_off <= 1'b1;
        end else if (status_we_i) begin
            status_word <= status_i;
        end else if (wb_wr && wb_ofs == rf_pkg::OFS_STATUS) begin
            status_word <= rf_pkg::psr_t'(merge(status_word, wb_dat_i, wb_sel_i));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < rf_pkg::NSAVED; i++) begin
                saved_words[i] <= '0;
            end
        end else if (exc_enter_i && exc_bank != rf_pkg::BANK_USR) begin
            saved_words[exc_slot] <= status_word;
        end else if (saved_we_i && has_saved) begin
            saved_words[slot] <= saved_i;
        end else if (wb_wr && wb_ofs == rf_pkg::OFS_SAVED && has_saved) begin
            saved_words[slot] <= rf_pkg::psr_t'(merge(saved_words[slot], wb_dat_i, wb_sel_i));
        end
    end

    assign current_status_word_o = status_word;
    assign saved_status_word_o = has_saved ? saved_words[slot] : '0;
    assign compact_o = compact;
    assign pc_o = pc_view;

    // ================================================================
    // wishbone slave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_hit && !wb_ack_o) begin
            case (wb_ofs)
                rf_pkg::OFS_STATUS: wb_dat_o <= status_word;
                rf_pkg::OFS_SAVED: wb_dat_o <= saved_status_word_o;
                rf_pkg::OFS_PC: wb_dat_o <= pc_view;
                rf_pkg::OFS_VIEW: wb_dat_o <= {27'h0, has_saved, 3'(bank), compact};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // ================================================================
    // assertions
    sequence s_enter;
        exc_enter_i;
    endsequence

    sequence s_entered;
        status_word.mode == $past(exc_mode_i) && !compact;
    endsequence

    property p_exc_link;
        @(posedge clk_i) disable iff (rst_i)
        s_enter |=> (gpr[$past(exc_link)] == $past(exc_ret_i)) ##0 s_entered;
    endproperty
    a_exc_link: assert property (p_exc_link) else $error("entry link or mode wrong");

    property p_call_link;
        @(posedge clk_i) disable iff (rst_i)
        branch_and_link_i && !exc_enter_i |=> gpr[$past(link_phys)] == $past(pc_view);
    endproperty
    a_call_link: assert property (p_call_link) else $error("link not loaded with pc");

    property p_wide_pc;
        @(posedge clk_i) disable iff (rst_i)
        !compact |-> pc_o[1:0] == 2'b00 && pc_o[31:2] == pc[31:2];
    endproperty
    a_wide_pc: assert property (p_wide_pc) else $error("wide pc low bits set");

    property p_compact_pc;
        @(posedge clk_i) disable iff (rst_i)
        compact |-> pc_o[0] == 1'b0 && pc_o[31:1] == pc[31:1];
    endproperty
    a_compact_pc: assert property (p_compact_pc) else $error("compact pc bit 0 set");

    property p_saved_capture;
        @(posedge clk_i) disable iff (rst_i)
        exc_enter_i && exc_bank != rf_pkg::BANK_USR |=> saved_words[$past(exc_slot)] == $past(status_word);
    endproperty
    a_saved_capture: assert property (p_saved_capture) else $error("saved word not captured");

    property p_fiq_private;
        @(posedge clk_i) disable iff (rst_i)
        bank == rf_pkg::BANK_FIQ && rd_a_i.idx == rf_pkg::FIQ_FIRST && !compact
        |=> rd_a_o == $past(gpr[rf_pkg::FIQ_BASE]);
    endproperty
    a_fiq_private: assert property (p_fiq_private) else $error("fiq bank not used");

    property p_svc_stack;
        @(posedge clk_i) disable iff (rst_i)
        bank == rf_pkg::BANK_SVC && rd_a_i.idx == rf_pkg::SP_IDX |=> rd_a_o == $past(gpr[rf_pkg::SVC_BASE]);
    endproperty
    a_svc_stack: assert property (p_svc_stack) else $error("svc stack not banked");

    property p_compact_hidden;
        @(posedge clk_i) disable iff (rst_i)
        compact && !rd_a_i.hi && rd_a_i.idx > rf_pkg::LOW_LAST && rd_a_i.idx < rf_pkg::SP_IDX |=> rd_a_o == '0;
    endproperty
    a_compact_hidden: assert property (p_compact_hidden) else $error("hidden register visible");

    property p_low_shared;
        @(posedge clk_i) disable iff (rst_i)
        rd_a_i.idx <= rf_pkg::LOW_LAST |=> rd_a_o == $past(gpr[5'(rd_a_i.idx)]);
    endproperty
    a_low_shared: assert property (p_low_shared) else $error("low register not shared");

    property p_system_no_saved;
        @(posedge clk_i) disable iff (rst_i)
        status_word.mode == rf_pkg::MODE_SYS |-> saved_status_word_o == '0;
    endproperty
    a_system_no_saved: assert property (p_system_no_saved) else $error("system has saved word");

    property p_mode_keeps;
        @(posedge clk_i) disable iff (rst_i)
        status_we_i && !gpr_write_any |=> gpr[$past(link_phys)] == $past(gpr[link_phys]);
    endproperty
    a_mode_keeps: assert property (p_mode_keeps) else $error("mode change altered register");
endmodule

// File: test/core_model.sv
// core-side partner model driving the register file's datapath ports
`timescale 1ns/1ns
module core_model (
    input wire logic clk_i,
    input wire logic [31:0] rd_a_o,
    output rf_pkg::rd_req_t rd_a_i,
    output rf_pkg::wr_req_t wr_i,
    output logic pc_we_i,
    output logic [31:0] pc_i,
    output logic branch_and_link_i,
    output logic exc_enter_i,
    output logic [4:0] exc_mode_i,
    output logic [31:0] exc_ret_i,
    output logic status_we_i,
    output rf_pkg::psr_t status_i
);
    // =========
    // idle values
    initial begin
        rd_a_i = '0;
        wr_i = '0;
        pc_we_i = 1'b0;
        pc_i = '0;
        branch_and_link_i = 1'b0;
        exc_enter_i = 1'b0;
        exc_mode_i = '0;
        exc_ret_i = '0;
        status_we_i = 1'b0;
        status_i = '0;
    end
    // =========
    // operand read, answer one edge later
    task automatic rd(input logic [3:0] idx, input logic hi, output logic [31:0] v);
        @(posedge clk_i);
        rd_a_i <= '{idx: idx, hi: hi};
        @(posedge clk_i);
        #1;
        v = rd_a_o;
    endtask
    task automatic wr(input logic [3:0] idx, input logic hi, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= '{en: 1'b1, idx: idx, hi: hi, data: d};
        @(posedge clk_i);
        wr_i.en <= 1'b0;
    endtask
    task automatic st(input logic [31:0] p);
        @(posedge clk_i);
        status_i <= rf_pkg::psr_t'(p);
        status_we_i <= 1'b1;
        @(posedge clk_i);
        status_we_i <= 1'b0;
    endtask
    task automatic pc(input logic [31:0] p);
        @(posedge clk_i);
        pc_i <= p;
        pc_we_i <= 1'b1;
        @(posedge clk_i);
        pc_we_i <= 1'b0;
    endtask
    task automatic call_link();
        @(posedge clk_i);
        branch_and_link_i <= 1'b1;
        @(posedge clk_i);
        branch_and_link_i <= 1'b0;
    endtask
    task automatic exc(input logic [4:0] m, input logic [31:0] r);
        @(posedge clk_i);
        exc_mode_i <= m;
        exc_ret_i <= r;
        exc_enter_i <= 1'b1;
        @(posedge clk_i);
        exc_enter_i <= 1'b0;
    endtask
endmodule

// File: test/tb_top.sv
// self-checking bench for the banked register file
`timescale 1ns/1ns
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    rf_pkg::rd_req_t rd_a_i;
    rf_pkg::wr_req_t wr_i;
    rf_pkg::psr_t status_i, cur, sav;
    logic pc_we_i, call_i, exc_i, st_we;
    logic [4:0] exc_mode_i;
    logic [31:0] pc_i, exc_ret_i, rd_a_o, rd_b_o, pc_o, wb_dat_o, v;
    logic compact_o, wb_ack_o;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [3:0] wb_sel_i = 4'hF;
    rf_pkg::rd_req_t rd_b_i = '0;
    logic saved_we_i = 1'b0;
    rf_pkg::psr_t saved_i = '0;
    int error_cnt = 0;
    int check_count = 0;
    logic [4:0] md[7] = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
    logic [4:0] vw[7] = '{5'h00, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1A, 5'h00};
    always #50 clk_i = ~clk_i;
    banked_register_file i_banked_register_file (.clk_i(clk_i), .rst_i(rst_i), .rd_a_i(rd_a_i),
        .rd_b_i(rd_b_i), .rd_a_o(rd_a_o), .rd_b_o(rd_b_o), .wr_i(wr_i), .pc_we_i(pc_we_i),
        .pc_i(pc_i), .pc_o(pc_o), .branch_and_link_i(call_i), .exc_enter_i(exc_i), .exc_mode_i(exc_mode_i),
        .exc_ret_i(exc_ret_i), .status_we_i(st_we), .status_i(status_i), .saved_we_i(saved_we_i),
        .saved_i(saved_i), .current_status_word_o(cur), .saved_status_word_o(sav),
        .compact_o(compact_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    core_model i_core_model (.clk_i(clk_i), .rd_a_o(rd_a_o), .rd_a_i(rd_a_i), .wr_i(wr_i), .pc_we_i(pc_we_i),
        .pc_i(pc_i), .branch_and_link_i(call_i), .exc_enter_i(exc_i), .exc_mode_i(exc_mode_i),
        .exc_ret_i(exc_ret_i), .status_we_i(st_we), .status_i(status_i));
    // =========
    // compare and bus helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] i, input logic hi, input logic [31:0] e);
        logic [31:0] q;
        i_core_model.rd(i, hi, q);
        chk($sformatf("reg %0d hi %0b", i, hi), e, q);
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        input logic [3:0] s = 4'hF);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("bus ack", 32'h00000001, {31'h0, n < 100});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        results();
    end
    // =========
    // tests
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("status", 32'h000000D3, cur);
        wb(1'b0, 8'h00, 32'h0, v);
        chk("bus status", 32'h000000D3, v);
        wb(1'b0, 8'h40, 32'h0, v);
        chk("unmapped", 32'h00000000, v);
        for (int i = 0; i < 15; i++) begin
            i_core_model.wr(4'(i), 1'b0, 32'h5A000000 + 32'(i));
        end
        for (int i = 0; i < 15; i++) begin
            rchk(4'(i), 1'b0, 32'h5A000000 + 32'(i));
        end
        i_core_model.st(32'h000000D0);
        rchk(4'hD, 1'b0, 32'h00000000);
        rchk(4'h8, 1'b0, 32'h5A000008);
        i_core_model.wr(4'hD, 1'b0, 32'h11110013);
        i_core_model.st(32'h000000D1);
        for (int i = 8; i < 15; i++) begin
            rchk(4'(i), 1'b0, 32'h00000000);
        end
        rchk(4'h7, 1'b0, 32'h5A000007);
        i_core_model.wr(4'h8, 1'b0, 32'h0000F108);
        i_core_model.st(32'h000000DF);
        rchk(4'h8, 1'b0, 32'h5A000008);
        rchk(4'hD, 1'b0, 32'h11110013);
        $display("test banking done");
        for (int i = 0; i < 7; i++) begin
            i_core_model.st({24'h0, 3'b110, md[i]});
            wb(1'b1, 8'h04, 32'h50000000 + 32'(i), v);
        end
        for (int i = 0; i < 7; i++) begin
            i_core_model.st({24'h0, 3'b110, md[i]});
            wb(1'b0, 8'h0C, 32'h0, v);
            chk("view", {27'h0, vw[i]}, v);
            chk("saved", vw[i][4] ? 32'h50000000 + 32'(i) : 32'h0, sav);
        end
        $display("test modes done");
        i_core_model.st(32'h000000D0);
        i_core_model.pc(32'h12345677);
        @(negedge clk_i);
        chk("pc wide", 32'h12345674, pc_o);
        wb(1'b1, 8'h08, 32'hFFFFFFFF, v);
        chk("pc ro", 32'h12345674, pc_o);
        i_core_model.st(32'h000000F0);
        @(negedge clk_i);
        chk("pc compact", 32'h12345676, pc_o);
        chk("compact flag", 32'h00000001, {31'h0, compact_o});
        rchk(4'h9, 1'b0, 32'h00000000);
        rchk(4'h9, 1'b1, 32'h5A000009);
        rchk(4'h3, 1'b0, 32'h5A000003);
        rchk(4'hD, 1'b0, 32'h11110013);
        rchk(4'hF, 1'b0, 32'h12345676);
        i_core_model.wr(4'hA, 1'b1, 32'h0000AAAA);
        rchk(4'hA, 1'b1, 32'h0000AAAA);
        @(posedge clk_i);
        rd_b_i <= '{idx: 4'h9, hi: 1'b1};
        @(posedge clk_i);
        @(negedge clk_i);
        chk("port b", 32'h5A000009, rd_b_o);
        wb(1'b0, 8'h00, 32'h0, v);
        chk("compact status", 32'h000000F0, v);
        wb(1'b1, 8'h00, 32'h9000FF00, v, 4'h8);
        wb(1'b0, 8'h00, 32'h0, v);
        chk("byte lane", 32'h900000F0, v);
        $display("test compact done");
        i_core_model.st(32'h000000D2);
        i_core_model.pc(32'h00001004);
        i_core_model.call_link();
        rchk(4'hE, 1'b0, 32'h00001004);
        i_core_model.st(32'hA0000010);
        rchk(4'hE, 1'b0, 32'h00000000);
        i_core_model.exc(5'h17, 32'h0000ABC8);
        @(negedge clk_i);
        chk("entry status", 32'hA0000097, cur);
        chk("entry saved", 32'hA0000010, sav);
        rchk(4'hE, 1'b0, 32'h0000ABC8);
        @(posedge clk_i);
        saved_we_i <= 1'b1;
        saved_i <= rf_pkg::psr_t'(32'h60000013);
        @(posedge clk_i);
        saved_we_i <= 1'b0;
        @(negedge clk_i);
        chk("saved write", 32'h60000013, sav);
        i_core_model.st(32'h00000010);
        @(posedge clk_i);
        saved_we_i <= 1'b1;
        saved_i <= rf_pkg::psr_t'(32'h11111111);
        @(posedge clk_i);
        saved_we_i <= 1'b0;
        i_core_model.st(32'h00000097);
        @(negedge clk_i);
        chk("saved kept", 32'h60000013, sav);
        $display("test link done");
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("reset status", 32'h000000D3, cur);
        rchk(4'hE, 1'b0, 32'h00000000);
        $display("test reset done");
        results();
    end
endmodule
